// *** core/mrrs_top.sv ***
// memory remap, sram and reset source recording
// assumes apb from the system, a simple one-cycle core memory bus, and that
// the reset network pulses one source line per reset event before presetn
//
// Overview of operation
// - little endian byte lanes in memory
// - 4 kB sram, 1024 words, base 0x40000
// - sram takes 8, 16, 32 bit accesses
// - vectors live in remappable bottom region
// - remap bit set puts sram at zero
// - remap bit clear puts nonvolatile at zero
// - any reset clears the remap bit
// - after reset run factory code first
// - status records last reset source bits
// - writing status bit 2 fires software reset
// - clear register clears matching status bits
// - upper status bits read zero
// - clear write keeping soft bit refires reset
// - status survives reset, other registers do not
// - sram contents survive warm resets
// - after power-on, sram valid only with flag
// - undefined address gives data abort
`timescale 1ns/1ns
module mrrs_top
	import mrrs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic por_event,
	input wire logic wdog_event,
	input wire logic ext_event,
	input wire logic download_event,
	input wire logic hv_lvf_enable,
	input wire logic hv_lvf_status,
	input wire logic kernel_done,
	output logic soft_reset_req,
	output logic kernel_run,
	output logic sram_valid,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	output logic mem_abort,
	output logic nvm_req,
	output logic [31:0] nvm_addr
);
	logic remap;
	logic [3:0] rst_stat;
	logic soft_fire;
	logic [31:0] sram [0:MRRS_SRAM_WORDS-1];
	logic [3:0] be;
	logic in_low;
	logic in_sram;
	logic in_nvm;
	logic to_sram;
	logic to_nvm;
	logic [31:0] phys;
	logic [9:0] widx;
	logic apb_wr, apb_rd;
	logic ram_ok;
	logic kernel;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// the remap bit lives only in flops cleared by presetn so every reset kind drops it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			remap <= 1'b0;
		else if (apb_wr && paddr == MRRS_MAP_CTRL_ADDR)
			remap <= pwdata[MRRS_REMAP_BIT]; // reserved bits dropped
	end

	a_remap_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(apb_wr && paddr == MRRS_MAP_CTRL_ADDR) |=> remap == $past(remap))
		else $error("remap moved without write");

	a_remap_clr: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_MAP_CTRL_ADDR && !pwdata[0] |=> !remap)
		else $error("remap not cleared by write");

	a_map_upper: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && !penable && paddr == MRRS_MAP_CTRL_ADDR |=> prdata[31:1] == 31'h0)
		else $error("map upper bits set");

	a_remap_read: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && !penable && paddr == MRRS_MAP_CTRL_ADDR |=> prdata[0] == $past(remap))
		else $error("remap read wrong");

	// status is not cleared by presetn: it must name the reset that just happened
	always_ff @(posedge pclk)
	begin
		if (apb_wr && paddr == MRRS_RST_CLR_ADDR)
			rst_stat <= rst_stat & ~pwdata[3:0];
		if (apb_wr && paddr == MRRS_RST_STAT_ADDR && pwdata[MRRS_SRC_SOFT])
			rst_stat[MRRS_SRC_SOFT] <= 1'b1;
		if (por_event)
			rst_stat <= 4'h1 << MRRS_SRC_POR;
		else if (wdog_event)
			rst_stat <= 4'h1 << MRRS_SRC_WDOG;
		else if (ext_event)
			rst_stat <= 4'h1 << MRRS_SRC_EXT;
	end

	a_wdog_stat: assert property (@(posedge pclk)
		wdog_event && !por_event |=> rst_stat == 4'h2)
		else $error("watchdog not recorded");

	a_ext_stat: assert property (@(posedge pclk)
		ext_event && !por_event && !wdog_event |=> rst_stat == 4'h8)
		else $error("external not recorded");

	a_soft_stat: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_RST_STAT_ADDR && pwdata[2] && !por_event && !wdog_event && !ext_event |=> rst_stat[2])
		else $error("soft bit not set");

	a_stat_warm: assert property (@(posedge pclk)
		!presetn && !por_event && !wdog_event && !ext_event && !apb_wr |=> rst_stat == $past(rst_stat))
		else $error("status lost in reset");

	a_clr_read: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && !penable && paddr == MRRS_RST_CLR_ADDR |=> prdata == 32'h0)
		else $error("clear register readable");

	a_stat_value: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && !penable && paddr == MRRS_RST_STAT_ADDR |=> prdata[3:0] == $past(rst_stat))
		else $error("status read wrong");

	always_comb
	begin
		soft_fire = 1'b0;
		if (apb_wr && paddr == MRRS_RST_STAT_ADDR && pwdata[MRRS_SRC_SOFT])
			soft_fire = 1'b1;
		if (apb_wr && paddr == MRRS_RST_CLR_ADDR && rst_stat[MRRS_SRC_SOFT] && !pwdata[MRRS_SRC_SOFT])
			soft_fire = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			soft_reset_req <= 1'b0;
		else
			soft_reset_req <= soft_fire;
	end

	a_soft_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		soft_reset_req && !soft_fire |=> !soft_reset_req)
		else $error("soft request too long");

	a_soft_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!soft_fire |=> !soft_reset_req)
		else $error("spurious soft request");

	a_clr_noref: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_RST_CLR_ADDR && pwdata[2] |=> !soft_reset_req)
		else $error("refire on clearing write");

	// factory code runs from reset release until the kernel reports done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			kernel <= 1'b1;
		else if (kernel_done)
			kernel <= 1'b0;
	end

	a_kernel_start: assert property (@(posedge pclk)
		$rose(presetn) |-> kernel_run)
		else $error("factory phase missing");

	a_kernel_end: assert property (@(posedge pclk) disable iff (!presetn)
		kernel_run && kernel_done |=> !kernel_run)
		else $error("factory phase not ended");

	a_kernel_stay: assert property (@(posedge pclk) disable iff (!presetn)
		!kernel_run |=> !kernel_run)
		else $error("factory phase restarted");
	assign kernel_run = kernel;

	// sram keeps contents over warm resets; only power-on or a download can spoil it
	always_ff @(posedge pclk)
	begin
		if (download_event)
			ram_ok <= 1'b0;
		else if (por_event)
			ram_ok <= hv_lvf_enable && hv_lvf_status;
		else if (wdog_event || ext_event)
			ram_ok <= ram_ok;
	end
	assign sram_valid = ram_ok;

	a_dl_invalid: assert property (@(posedge pclk)
		download_event |=> !sram_valid)
		else $error("sram valid after download");

	a_por_valid: assert property (@(posedge pclk)
		por_event && !download_event |=> sram_valid == $past(hv_lvf_enable && hv_lvf_status))
		else $error("power-on validity wrong");

	a_warm_keep: assert property (@(posedge pclk)
		(wdog_event || ext_event) && !por_event && !download_event |=> sram_valid == $past(sram_valid))
		else $error("warm reset spoiled sram");

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (apb_rd && !penable)
			case (paddr)
				MRRS_MAP_CTRL_ADDR: prdata <= {31'h0, remap};
				MRRS_RST_STAT_ADDR: prdata <= {28'h0, rst_stat};
				default: prdata <= 32'h0;
			endcase
	end

	// memory decode; vectors 0..0x20 fall in the remappable window
	always_comb
	begin
		in_low = mem_addr < MRRS_REMAP_SIZE;
		to_sram = 1'b0;
		to_nvm = 1'b0;
		phys = mem_addr;
		if (in_low)
		begin
			if (remap)
			begin
				to_sram = mem_addr < MRRS_SRAM_SIZE;
				phys = MRRS_SRAM_BASE + mem_addr;
			end
			else
			begin
				to_nvm = 1'b1;
				phys = MRRS_NVM_BASE + mem_addr;
			end
		end
		in_sram = mem_addr >= MRRS_SRAM_BASE && mem_addr < MRRS_SRAM_BASE + MRRS_SRAM_SIZE;
		in_nvm = mem_addr >= MRRS_NVM_BASE && mem_addr < MRRS_NVM_BASE + MRRS_NVM_SIZE;
		to_sram = to_sram || in_sram;
		to_nvm = to_nvm || in_nvm;
		case (mem_size)
			2'h0: be = 4'h1 << mem_addr[1:0];
			2'h1: be = mem_addr[1] ? 4'hc : 4'h3;
			default: be = 4'hf;
		endcase
	end
	assign widx = phys[11:2];

	a_byte_lane: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_size == 2'h0 |-> $onehot(be))
		else $error("byte lane not single");

	a_half_lane: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_size == 2'h1 |-> be == 4'h3 || be == 4'hc)
		else $error("half lane wrong");

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			always_ff @(posedge pclk)
			begin
				if (mem_req && mem_we && to_sram && be[g])
					sram[widx][8*g +: 8] <= mem_wdata[8*g +: 8];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mem_rdata <= 32'h0;
			mem_ack <= 1'b0;
			mem_abort <= 1'b0;
		end
		else
		begin
			mem_ack <= mem_req && (to_sram || to_nvm);
			mem_abort <= mem_req && !to_sram && !to_nvm;
			if (mem_req && !mem_we && to_sram)
				mem_rdata <= sram[widx]; // full word per cycle
		end

	assign nvm_req = mem_req && to_nvm && !to_sram;
	assign nvm_addr = phys;

	a_one_answer: assert property (@(posedge pclk) disable iff (!presetn)
		!(mem_ack && mem_abort))
		else $error("ack and abort together");

	a_ack_req: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req |=> mem_ack || mem_abort)
		else $error("request unanswered");

	a_no_req_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!mem_req |=> !mem_ack && !mem_abort)
		else $error("answer without request");

	a_sram_hit: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_addr >= MRRS_SRAM_BASE && mem_addr < MRRS_SRAM_BASE + MRRS_SRAM_SIZE |=> mem_ack && !mem_abort)
		else $error("sram access refused");

	a_remap_sram: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && remap && mem_addr < MRRS_SRAM_SIZE |=> mem_ack && !mem_abort)
		else $error("remapped sram refused");

	a_remap_gap: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && remap && mem_addr >= MRRS_SRAM_SIZE && mem_addr < MRRS_REMAP_SIZE |=> mem_abort)
		else $error("gap above remapped sram");

	a_nvm_phys: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_addr >= MRRS_NVM_BASE && mem_addr < MRRS_NVM_BASE + MRRS_NVM_SIZE |-> nvm_req && nvm_addr == mem_addr)
		else $error("absolute nvm not forwarded");

	a_vec_remap: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && remap && mem_addr <= MRRS_VEC_TOP |-> !nvm_req)
		else $error("vectors not remapped");

	a_remap_reset: assert property (@(posedge pclk) $rose(presetn) |-> !remap) else $error("remap not cleared");
	a_remap_set: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_MAP_CTRL_ADDR |=> remap == $past(pwdata[0])) else $error("remap write lost");
	a_soft_fire: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_RST_STAT_ADDR && pwdata[2] |=> soft_reset_req) else $error("no soft reset");
	a_soft_refire: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_RST_CLR_ADDR && rst_stat[2] && !pwdata[2] |=> soft_reset_req)
		else $error("no refire");
	a_clr_bits: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && paddr == MRRS_RST_CLR_ADDR && !por_event && !wdog_event && !ext_event
		|=> (rst_stat & $past(pwdata[3:0])) == 4'h0) else $error("clear failed");
	a_por_stat: assert property (@(posedge pclk) por_event |=> rst_stat == 4'h1) else $error("por not recorded");
	a_abort_undef: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_addr == MRRS_NVM_BASE + MRRS_NVM_SIZE |=> mem_abort && !mem_ack) else $error("no abort");
	a_low_nvm: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && !remap && mem_addr <= MRRS_VEC_TOP |-> nvm_req && nvm_addr == MRRS_NVM_BASE + mem_addr)
		else $error("bad nvm redirect");
	a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && !penable && paddr == MRRS_RST_STAT_ADDR |=> prdata[31:4] == 28'h0) else $error("upper bits set");
endmodule // mrrs_top

// *** core/mrrs_pkg.sv ***
// package for the memory remap and reset source block
// assumes a 32-bit apb register bus and a 32-bit core memory bus
package mrrs_pkg;
	localparam logic [31:0] MRRS_MAP_CTRL_ADDR = 32'hffff0220;
	localparam logic [31:0] MRRS_RST_STAT_ADDR = 32'hffff0230;
	localparam logic [31:0] MRRS_RST_CLR_ADDR = 32'hffff0234;
	localparam logic [31:0] MRRS_INFO_ADDR = 32'hffff0238;
	localparam int MRRS_REMAP_BIT = 0;
	localparam int MRRS_SRC_POR = 0;
	localparam int MRRS_SRC_WDOG = 1;
	localparam int MRRS_SRC_SOFT = 2;
	localparam int MRRS_SRC_EXT = 3;
	localparam logic [3:0] MRRS_STAT_RESET = 4'h0;
	localparam logic [31:0] MRRS_SRAM_BASE = 32'h00040000;
	localparam logic [31:0] MRRS_NVM_BASE = 32'h00080000;
	localparam logic [31:0] MRRS_NVM_SIZE = 32'h00010000;
	localparam logic [31:0] MRRS_SRAM_SIZE = 32'h00001000;
	localparam logic [31:0] MRRS_REMAP_SIZE = 32'h00010000;
	localparam logic [31:0] MRRS_VEC_TOP = 32'h00000020;
	localparam int MRRS_SRAM_WORDS = 1024;
	localparam int MRRS_HIGH_VOLTAGE_CONFIG_LVF_BIT = 4;
	localparam int MRRS_HIGH_VOLTAGE_STATUS_LVF_BIT = 2;
	localparam int MRRS_SOFT_PULSE_NS = 10;
	localparam int MRRS_CLK_NS = 10;
	localparam int MRRS_SOFT_PULSE_CYC = (MRRS_SOFT_PULSE_NS + MRRS_CLK_NS - 1) / MRRS_CLK_NS;
endpackage

// *** testbench/mrrs_rst_model.sv ***
// reset network model: merges the board reset with software reset requests
// assumes one clock; kernel_done comes KDLY cycles after presetn is released
`timescale 1ns/1ns
module mrrs_rst_model #(parameter int KDLY = 3)
(
	input wire logic pclk,
	input wire logic ext_rstn,
	input wire logic soft_reset_req,
	output logic presetn,
	output logic kernel_done
);
	logic [1:0] hold;
	int cnt;
	always_ff @(posedge pclk or negedge ext_rstn)
	begin
		if (!ext_rstn)
		begin
			hold <= 2'h2;
			presetn <= 1'b0;
			cnt <= 0;
			kernel_done <= 1'b0;
		end
		else
		begin
			kernel_done <= (cnt == 1);
			if (soft_reset_req)
			begin
				hold <= 2'h2;
				presetn <= 1'b0;
			end
			else if (hold != 2'h0)
				hold <= hold - 2'h1;
			else if (!presetn)
			begin
				presetn <= 1'b1;
				cnt <= KDLY; // factory code runs a while before user code
			end
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule // mrrs_rst_model

// *** testbench/tb_top.sv ***
// bench for the remap and reset source block with a reference model
// assumes the reset model drives presetn and kernel_done
`timescale 1ns/1ns
module tb_top
	import mrrs_pkg::*;
;
	logic pclk = 0, ext_rstn = 0, psel = 0, penable = 0, pwrite = 0, mem_req = 0, mem_we = 0, mab, nv;
	logic por_event = 0, wdog_event = 0, ext_event = 0, download_event = 0, hv_lvf_enable = 0, hv_lvf_status = 0;
	logic [1:0] mem_size = 0;
	logic [31:0] paddr = 0, pwdata = 0, mem_addr = 0, mem_wdata = 0, rd, mrd, na, prdata, mem_rdata, nvm_addr;
	logic pready, pslverr, soft_reset_req, kernel_run, sram_valid, mem_ack, mem_abort, nvm_req, presetn, kernel_done;
	logic [15:0] lf = 16'hf9b6;
	logic [31:0] ram_m [int];
	int num_errors = 0, tests_run = 0, cyc = 0;
	mrrs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.por_event, .wdog_event, .ext_event, .download_event, .hv_lvf_enable, .hv_lvf_status, .kernel_done,
		.soft_reset_req, .kernel_run, .sram_valid, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .mem_abort, .nvm_req, .nvm_addr);
	mrrs_rst_model #(.KDLY(3)) i_rst (.pclk, .ext_rstn, .soft_reset_req, .presetn, .kernel_done);
	initial forever #5 pclk = ~pclk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 0; penable <= 0;
	endtask
	// a single core access; the answer is registered on the taking edge and read 1 ns later
	task mem(input logic w, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		mem_req <= 1; mem_we <= w; mem_size <= s; mem_addr <= a; mem_wdata <= d;
		#1 nv = nvm_req; na = nvm_addr;
		@(posedge pclk);
		mem_req <= 0;
		#1 mrd = mem_rdata; mab = mem_abort;
		chk("resp", 1, mem_ack ^ mem_abort);
	endtask
	task ev(input logic [2:0] v);
		@(posedge pclk);
		{ext_event, wdog_event, por_event} <= v;
		@(posedge pclk);
		{ext_event, wdog_event, por_event} <= 0;
	endtask
	task boot;
		for (int i = 0; i < 9 && kernel_run !== 1'b1; i++) @(posedge pclk);
		for (int i = 0; i < 30 && kernel_run !== 1'b0; i++) @(posedge pclk);
		chk("kernel_run", 0, kernel_run);
	endtask
	task rst;
		@(posedge pclk);
		ext_rstn <= 0;
		repeat (3) @(posedge pclk);
		ext_rstn <= 1;
		boot();
	endtask
	task stat(input logic [31:0] e);
		apb(0, MRRS_RST_STAT_ADDR, 0);
		chk("status", e, rd);
		chk("pslverr", 0, pslverr);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			hv_lvf_enable <= i[1]; hv_lvf_status <= i[0];
			ev(3'b001);
			rst();
			stat(32'h1);
			chk("sram_valid", i == 3, sram_valid);
		end
		$display("power-on test done");
		for (int j = 0; j < 4; j++)
		begin
			lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
			ram_m[j] = {lf, ~lf};
			mem(1, 2, MRRS_SRAM_BASE + 4 * j, ram_m[j]);
		end
		mem(1, 0, MRRS_SRAM_BASE + 1, {4{8'hab}});
		mem(1, 1, MRRS_SRAM_BASE + 2, {2{16'hc3d4}});
		ram_m[0][31:8] = 24'hc3d4ab;
		apb(1, MRRS_MAP_CTRL_ADDR, 1);
		mem(0, 2, 0, 0);
		chk("remapped", ram_m[0], mrd);
		mem(0, 2, MRRS_SRAM_BASE + 4, 0);
		chk("sram", ram_m[1], mrd);
		mem(0, 2, 32'h1000, 0);
		chk("abort", 1, mab);
		apb(1, MRRS_MAP_CTRL_ADDR, 0);
		mem(0, 2, 32'h20, 0);
		chk("nvm", 32'h80020, nv ? na : 32'h0);
		mem(0, 2, MRRS_NVM_BASE + 4, 0);
		chk("nvm_abs", MRRS_NVM_BASE + 4, nv ? na : 32'h0);
		mem(1, 2, 32'h00100000, 0);
		chk("abort", 1, mab);
		apb(0, MRRS_INFO_ADDR, 0);
		chk("unmapped", 0, rd);
		$display("memory test done");
		apb(1, MRRS_MAP_CTRL_ADDR, 1);
		ev(3'b010);
		rst();
		apb(0, MRRS_MAP_CTRL_ADDR, 0);
		chk("remap", 0, rd);
		stat(32'h2);
		mem(0, 2, MRRS_SRAM_BASE + 4, 0);
		chk("kept", ram_m[1], mrd);
		ev(3'b100);
		rst();
		stat(32'h8);
		apb(1, MRRS_RST_CLR_ADDR, 32'hff);
		apb(0, MRRS_RST_CLR_ADDR, 0);
		chk("clr_read", 0, rd);
		stat(32'h0);
		apb(1, MRRS_RST_STAT_ADDR, 4);
		#1 chk("soft", 1, soft_reset_req);
		boot();
		stat(32'h4);
		apb(1, MRRS_RST_CLR_ADDR, 1);
		#1 chk("soft", 1, soft_reset_req);
		boot();
		apb(1, MRRS_RST_CLR_ADDR, 4);
		#1 chk("soft", 0, soft_reset_req);
		stat(32'h0);
		download_event <= 1;
		@(posedge pclk);
		download_event <= 0;
		@(posedge pclk);
		chk("sram_valid", 0, sram_valid);
		$display("reset source test done");
		give_verdict();
	end
endmodule // tb_top
